// [rtl/ptc_pkg.sv]
package ptc_pkg;

    // ****************************************************************
    // register word indices (printed offsets are not all word aligned,
    // so each offset is an index and the byte address is four times it)
    // ****************************************************************
    localparam logic [7:0]  IDX_INTR_CTRL    = 8'h0b;
    localparam logic [7:0]  IDX_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0]  IDX_TIMER_COUNT  = 8'h11;
    localparam logic [7:0]  IDX_TIMER_CTRL   = 8'h12;
    localparam logic [7:0]  IDX_CAP_LOW      = 8'h15;
    localparam logic [7:0]  IDX_CAP_HIGH     = 8'h16;
    localparam logic [7:0]  IDX_UNIT_CTRL    = 8'h17;
    localparam logic [7:0]  IDX_PERIPH_EN    = 8'h8c;
    localparam logic [7:0]  IDX_TIMER_PERIOD = 8'h92;
    localparam logic [7:0]  IDX_WIDE_TIMER   = 8'ha0;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int          FLAG_PERIOD_BIT  = 1;
    localparam int          FLAG_UNIT_BIT    = 2;
    localparam int          RUN_BIT          = 2;
    localparam logic [7:0]  PERIOD_RESET     = 8'hff;
    localparam logic [7:0]  COUNT_RESET      = 8'h00;
    localparam logic [6:0]  TCTRL_RESET      = 7'h00;
    localparam logic [7:0]  UCTRL_RESET      = 8'h00;
    localparam logic [7:0]  FLAGS_RESET      = 8'h00;
    localparam logic [3:0]  PRE_DIV4_LAST    = 4'h3;
    localparam logic [3:0]  PRE_DIV16_LAST   = 4'hf;
    localparam logic [3:0]  CAP_DIV4_LAST    = 4'h3;
    localparam logic [3:0]  CAP_DIV16_LAST   = 4'hf;

    // ****************************************************************
    // unit mode codes
    // ****************************************************************
    localparam logic [3:0]  MODE_OFF         = 4'h0;
    localparam logic [3:0]  MODE_CMP_TOGGLE  = 4'h2;
    localparam logic [3:0]  MODE_CAP_FALL    = 4'h4;
    localparam logic [3:0]  MODE_CAP_RISE    = 4'h5;
    localparam logic [3:0]  MODE_CAP_RISE4   = 4'h6;
    localparam logic [3:0]  MODE_CAP_RISE16  = 4'h7;
    localparam logic [3:0]  MODE_CMP_SET     = 4'h8;
    localparam logic [3:0]  MODE_CMP_CLEAR   = 4'h9;
    localparam logic [3:0]  MODE_CMP_SOFT    = 4'ha;
    localparam logic [3:0]  MODE_CMP_TRIG    = 4'hb;

    typedef enum logic [1:0] {
        STEER_SINGLE,
        STEER_FULL_FWD,
        STEER_HALF,
        STEER_FULL_REV
    } ptc_steer_t;

    // bus data phase bookkeeping
    typedef struct packed {
        logic       pend;
        logic       write;
        logic [7:0] index;
        logic       valid;
    } ptc_bus_t;

    // all block state
    typedef struct packed {
        ptc_bus_t    bus;
        logic [7:0]  count;
        logic [7:0]  period;
        logic [6:0]  tctrl;
        logic [3:0]  pre_cnt;
        logic [3:0]  post_cnt;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [7:0]  intr_ctrl;
        logic [7:0]  uctrl;
        logic [15:0] capture;
        logic [3:0]  cap_cnt;
        logic        pin_prev;
        logic        cmp_out;
        logic        match_pulse;
        logic        tmr_reset;
        logic        adc_start;
        logic [3:0]  pin_oe;
        logic [31:0] rdata;
    } ptc_state_t;

endpackage

// [rtl/ptc_top.sv]
// Notes on behaviour
// - timer counts up, wraps after matching period
// - period register read/write, resets to ones
// - count register read/write, reset clears it
// - input prescaler divides by 1, 4, 16
// - postscaler divides matches by N+1, sets flag
// - count or control write clears both scalers
// - control write keeps timer count
// - run bit gates timer counting
// - pre-postscaler match pulse goes to serial port
// - capture value is two byte registers
// - mode zero resets unit, reserved codes idle
// - capture modes: fall, rise, 4th, 16th rise
// - compare codes toggle, set, clear, flag only
// - trigger code resets wide timer, starts conversion only when adc_enabled is high
// - pwm codes choose pin pair polarity
// - steering field chooses pwm pin usage
// - duty low bits matter in pwm only
// - capture/compare use wide timer, pwm period timer
// - capture copies wide timer, sets flag; software clears
// - later capture overwrites unread value
// - edge prescaler cleared outside capture modes
// - prescaler switch keeps edge count; software masks
`timescale 1ns/1ns
module ptc_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timer side
    input  wire logic [15:0] wide_timer_count,
    input  wire logic        adc_enabled,
    input  wire logic        capture_pin,
    output logic             period_match_pulse,
    output logic             wide_timer_reset,
    output logic             adc_start,
    // output pins
    output logic             drive_out_a,
    output logic [3:0]       drive_out_oe,
    output logic             period_match_flag,
    output logic             unit_event_flag
);

    // ****************************************************************
    // state
    // ****************************************************************
    ptc_pkg::ptc_state_t s_q;
    ptc_pkg::ptc_state_t s_d;

    logic [3:0]  mode;
    logic        is_capture;
    logic        is_compare;
    logic        is_pwm;
    logic        tick;
    logic        match;
    logic        post_fire;
    logic        cap_event;
    logic        cmp_match;
    logic        wr_count;
    logic        wr_tctrl;
    logic [7:0]  wbyte;
    logic        addr_phase;
    logic [3:0]  pre_last;
    logic [31:0] rd_val;

    // prescaler terminal count for a select code
    function automatic logic [3:0] pre_limit(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        if (sel[1])
            r = ptc_pkg::PRE_DIV16_LAST;
        else if (sel[0])
            r = ptc_pkg::PRE_DIV4_LAST;
        return r;
    endfunction

    // register read mux, unmapped reads zero
    function automatic logic [31:0] read_reg(input ptc_pkg::ptc_state_t st,
                                             input logic [7:0]          idx);
        logic [31:0] r;
        r = 32'h0;
        unique case (idx)
            ptc_pkg::IDX_INTR_CTRL:    r = {24'h0, st.intr_ctrl};
            ptc_pkg::IDX_PERIPH_FLAGS: r = {24'h0, st.flags};
            ptc_pkg::IDX_TIMER_COUNT:  r = {24'h0, st.count};
            ptc_pkg::IDX_TIMER_CTRL:   r = {25'h0, st.tctrl};
            ptc_pkg::IDX_CAP_LOW:      r = {24'h0, st.capture[7:0]};
            ptc_pkg::IDX_CAP_HIGH:     r = {24'h0, st.capture[15:8]};
            ptc_pkg::IDX_UNIT_CTRL:    r = {24'h0, st.uctrl};
            ptc_pkg::IDX_PERIPH_EN:    r = {24'h0, st.enables};
            ptc_pkg::IDX_TIMER_PERIOD: r = {24'h0, st.period};
            default:                   r = 32'h0;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        s_d        = s_q;
        mode       = s_q.uctrl[3:0];
        is_capture = (mode[3:2] == 2'b01);
        is_pwm     = (mode[3:2] == 2'b11);
        // reserved codes 0001/0011 and off fall in neither set
        is_compare = (mode == ptc_pkg::MODE_CMP_TOGGLE) || (mode[3:2] == 2'b10);
        addr_phase = hsel && hready && htrans[1];
        wbyte      = hwdata[7:0];
        wr_count   = s_q.bus.pend && s_q.bus.write && s_q.bus.valid
                     && (s_q.bus.index == ptc_pkg::IDX_TIMER_COUNT);
        wr_tctrl   = s_q.bus.pend && s_q.bus.write && s_q.bus.valid
                     && (s_q.bus.index == ptc_pkg::IDX_TIMER_CTRL);

        // bus: accept address phase; zero wait states
        s_d.bus.pend  = addr_phase;
        s_d.bus.write = hwrite;
        s_d.bus.index = haddr[9:2];
        s_d.bus.valid = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);
        rd_val        = read_reg(s_q, haddr[9:2]);
        // misaligned or out-of-range reads are refused and return zero
        s_d.rdata     = (addr_phase && !hwrite && s_d.bus.valid) ? rd_val : 32'h0;

        // timer path: prescaler, count, postscaler
        pre_last  = pre_limit(s_q.tctrl[1:0]);
        tick      = s_q.tctrl[ptc_pkg::RUN_BIT] && (s_q.pre_cnt >= pre_last);
        match     = tick && (s_q.count == s_q.period);
        post_fire = match && (s_q.post_cnt >= s_q.tctrl[6:3]);
        if (s_q.tctrl[ptc_pkg::RUN_BIT])
        begin
            // stopped timer simply keeps its state
            s_d.pre_cnt = tick ? 4'h0 : s_q.pre_cnt + 4'h1;
            if (tick)
                s_d.count = match ? 8'h00 : s_q.count + 8'h01;
            if (match)
                s_d.post_cnt = post_fire ? 4'h0 : s_q.post_cnt + 4'h1;
        end
        s_d.match_pulse = match;
        if (post_fire)
            s_d.flags[ptc_pkg::FLAG_PERIOD_BIT] = 1'b1;

        // capture edge detection and prescale
        s_d.pin_prev = capture_pin;
        cap_event    = 1'b0;
        if (!is_capture)
            s_d.cap_cnt = 4'h0;
        else if (mode == ptc_pkg::MODE_CAP_FALL)
            cap_event = s_q.pin_prev && !capture_pin;
        else if (!s_q.pin_prev && capture_pin)
        begin
            // edge count survives a prescale change on purpose
            unique case (mode)
                ptc_pkg::MODE_CAP_RISE:  cap_event = 1'b1;
                ptc_pkg::MODE_CAP_RISE4: cap_event =
                    (s_q.cap_cnt[1:0] == ptc_pkg::CAP_DIV4_LAST[1:0]);
                default:                 cap_event = (s_q.cap_cnt == ptc_pkg::CAP_DIV16_LAST);
            endcase
            s_d.cap_cnt = s_q.cap_cnt + 4'h1;
        end
        if (cap_event)
            s_d.capture = wide_timer_count;

        // compare against wide timer
        cmp_match     = is_compare && (wide_timer_count == s_q.capture);
        s_d.tmr_reset = cmp_match && (mode == ptc_pkg::MODE_CMP_TRIG);
        s_d.adc_start = cmp_match && (mode == ptc_pkg::MODE_CMP_TRIG) && adc_enabled;
        if (cmp_match)
        begin
            unique case (mode)
                ptc_pkg::MODE_CMP_TOGGLE: s_d.cmp_out = !s_q.cmp_out;
                ptc_pkg::MODE_CMP_SET:    s_d.cmp_out = 1'b1;
                ptc_pkg::MODE_CMP_CLEAR:  s_d.cmp_out = 1'b0;
                default:                  s_d.cmp_out = s_q.cmp_out;
            endcase
        end
        if (mode == ptc_pkg::MODE_OFF)
            s_d.cmp_out = 1'b0;
        else if (is_pwm)
            // pwm waveform lives elsewhere; pin a shows idle level by polarity
            s_d.cmp_out = mode[1];

        // pin steering: enables per configuration
        if (!is_pwm)
            s_d.pin_oe = {3'b000, is_compare};
        else
        begin
            unique case (ptc_pkg::ptc_steer_t'(s_q.uctrl[7:6]))
                ptc_pkg::STEER_SINGLE:   s_d.pin_oe = 4'b0001;
                ptc_pkg::STEER_HALF:     s_d.pin_oe = 4'b0011;
                ptc_pkg::STEER_FULL_FWD: s_d.pin_oe = 4'b1111;
                ptc_pkg::STEER_FULL_REV: s_d.pin_oe = 4'b1111;
            endcase
        end

        // register writes in the data phase
        if (s_q.bus.pend && s_q.bus.write && s_q.bus.valid)
        begin
            unique case (s_q.bus.index)
                ptc_pkg::IDX_INTR_CTRL:    s_d.intr_ctrl = wbyte;
                ptc_pkg::IDX_PERIPH_FLAGS: s_d.flags     = wbyte;
                ptc_pkg::IDX_TIMER_COUNT:  s_d.count     = wbyte;
                ptc_pkg::IDX_TIMER_CTRL:   s_d.tctrl     = wbyte[6:0];
                ptc_pkg::IDX_CAP_LOW:      s_d.capture[7:0]  = wbyte;
                ptc_pkg::IDX_CAP_HIGH:     s_d.capture[15:8] = wbyte;
                ptc_pkg::IDX_UNIT_CTRL:    s_d.uctrl     = wbyte;
                ptc_pkg::IDX_PERIPH_EN:    s_d.enables   = wbyte;
                ptc_pkg::IDX_TIMER_PERIOD: s_d.period    = wbyte;
                default:                   s_d.enables   = s_d.enables;
            endcase
        end
        if (wr_count || wr_tctrl)
        begin
            s_d.pre_cnt  = 4'h0;
            s_d.post_cnt = 4'h0;
        end

        // hardware set wins over software clear
        if (post_fire)
            s_d.flags[ptc_pkg::FLAG_PERIOD_BIT] = 1'b1;
        if (cap_event || cmp_match)
            s_d.flags[ptc_pkg::FLAG_UNIT_BIT] = 1'b1;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q        <= '0;
            s_q.period <= ptc_pkg::PERIOD_RESET;
            s_q.count  <= ptc_pkg::COUNT_RESET;
            s_q.tctrl  <= ptc_pkg::TCTRL_RESET;
            s_q.uctrl  <= ptc_pkg::UCTRL_RESET;
            s_q.flags  <= ptc_pkg::FLAGS_RESET;
        end
        else
            s_q <= s_d;
    end

    // outputs straight from flip-flops, except hreadyout and hresp, which are tied to constants
    assign hrdata             = s_q.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign period_match_pulse = s_q.match_pulse;
    assign wide_timer_reset   = s_q.tmr_reset;
    assign adc_start          = s_q.adc_start;
    assign drive_out_a        = s_q.cmp_out;
    assign drive_out_oe       = s_q.pin_oe;
    assign period_match_flag  = s_q.flags[ptc_pkg::FLAG_PERIOD_BIT];
    assign unit_event_flag    = s_q.flags[ptc_pkg::FLAG_UNIT_BIT];

    // ****************************************************************
    // checks
    // ****************************************************************
    a_period_wrap: assert property (@(posedge clk) disable iff (rst)
        (s_q.tctrl[2] && tick && s_q.count == s_q.period && !wr_count) |=> s_q.count == 8'h00)
        else $error("timer did not wrap after period match");

    a_ctrl_keeps_count: assert property (@(posedge clk) disable iff (rst)
        (wr_tctrl && !tick) |=> s_q.count == $past(s_q.count))
        else $error("control write disturbed count");

    a_scaler_clear: assert property (@(posedge clk) disable iff (rst)
        (wr_count || wr_tctrl) |=> (s_q.pre_cnt == 4'h0 && s_q.post_cnt == 4'h0))
        else $error("scalers not cleared by write");

    a_stop_holds: assert property (@(posedge clk) disable iff (rst)
        (!s_q.tctrl[2] && !s_q.bus.pend) |=> s_q.count == $past(s_q.count))
        else $error("stopped timer moved");

    a_capture_copy: assert property (@(posedge clk) disable iff (rst)
        cap_event |=> (s_q.capture == $past(wide_timer_count) && unit_event_flag))
        else $error("capture did not copy or flag");

    a_edge_cnt_idle: assert property (@(posedge clk) disable iff (rst)
        !is_capture |=> s_q.cap_cnt == 4'h0)
        else $error("edge counter not cleared");

    a_match_pulse: assert property (@(posedge clk) disable iff (rst)
        match |=> period_match_pulse)
        else $error("match pulse missing");

    a_trigger_reset: assert property (@(posedge clk) disable iff (rst)
        (cmp_match && mode == ptc_pkg::MODE_CMP_TRIG) |=> (wide_timer_reset && unit_event_flag))
        else $error("special trigger missing");

    a_post_flag: assert property (@(posedge clk) disable iff (rst)
        post_fire |=> period_match_flag)
        else $error("postscaler did not set flag");

    a_off_output: assert property (@(posedge clk) disable iff (rst)
        (mode == ptc_pkg::MODE_OFF) |=> !drive_out_a)
        else $error("unit off but compare output high");

endmodule

// [verif/ptc_partner.sv]
`timescale 1ns/1ns
module ptc_partner (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // trigger from the block
    input  wire logic        wide_timer_reset,
    // capture source and wide time base
    output logic             capture_pin,
    output logic [15:0]      wide_timer_count
);
    // wide time base holds what the bench presets; the trigger zeroes it
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            wide_timer_count <= 16'h0000;
        else if (wide_timer_reset)
            wide_timer_count <= 16'h0000;
    end

    initial capture_pin = 1'b0;

    // k pulses; count is v across the rise and v+1 across the fall,
    // so the captured value tells which edge was used
    task automatic pulses(input int k, input logic [15:0] v);
        repeat (k)
        begin
            @(posedge clk);
            wide_timer_count <= v;
            capture_pin      <= 1'b1;
            repeat (3) @(posedge clk);
            wide_timer_count <= v + 16'h0001;
            repeat (2) @(posedge clk);
            capture_pin      <= 1'b0;
            repeat (4) @(posedge clk);
            wide_timer_count <= ~v;
        end
    endtask

    // one-cycle equality, so a level- or edge-based compare acts once
    task automatic match(input logic [15:0] v);
        @(posedge clk);
        wide_timer_count <= v;
        @(posedge clk);
        wide_timer_count <= ~v;
    endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    localparam logic [31:0] A_FLG = {22'h0, ptc_pkg::IDX_PERIPH_FLAGS, 2'b00};
    localparam logic [31:0] A_CNT = {22'h0, ptc_pkg::IDX_TIMER_COUNT, 2'b00};
    localparam logic [31:0] A_CTL = {22'h0, ptc_pkg::IDX_TIMER_CTRL, 2'b00};
    localparam logic [31:0] A_CLO = {22'h0, ptc_pkg::IDX_CAP_LOW, 2'b00};
    localparam logic [31:0] A_CHI = {22'h0, ptc_pkg::IDX_CAP_HIGH, 2'b00};
    localparam logic [31:0] A_UCT = {22'h0, ptc_pkg::IDX_UNIT_CTRL, 2'b00};
    localparam logic [31:0] A_ENA = {22'h0, ptc_pkg::IDX_PERIPH_EN, 2'b00};
    localparam logic [31:0] A_PER = {22'h0, ptc_pkg::IDX_TIMER_PERIOD, 2'b00};
    logic        clk, rst, hsel, hwrite, hreadyout, hresp, adc_enabled, capture_pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] wide_timer_count;
    logic        period_match_pulse, wide_timer_reset, adc_start, drive_out_a;
    logic        period_match_flag, unit_event_flag;
    logic [3:0]  drive_out_oe;
    int          num_errors, n_tests, npulse, nwrst, nadc, t, n, snap;

    ptc_top ptc_top_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wide_timer_count(wide_timer_count), .adc_enabled(adc_enabled),
        .capture_pin(capture_pin), .period_match_pulse(period_match_pulse),
        .wide_timer_reset(wide_timer_reset), .adc_start(adc_start),
        .drive_out_a(drive_out_a), .drive_out_oe(drive_out_oe),
        .period_match_flag(period_match_flag), .unit_event_flag(unit_event_flag));
    ptc_partner ptc_partner_inst (.clk(clk), .rst(rst),
        .wide_timer_reset(wide_timer_reset), .capture_pin(capture_pin),
        .wide_timer_count(wide_timer_count));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // pulses counted on the falling edge so posedge snapshots never race
    always @(negedge clk)
    begin
        npulse += (period_match_pulse === 1'b1);
        nwrst  += (wide_timer_reset === 1'b1);
        nadc   += (adc_start === 1'b1);
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one single ahb-lite transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // bounded wait for the next match pulse; t gives the spacing
    task automatic wait_pulse;
        t = 0;
        do begin @(posedge clk); t++; end while (period_match_pulse !== 1'b1 && t < 4000);
    endtask
    task automatic wait_flag;
        t = 0;
        do begin @(posedge clk); t++; end while (period_match_flag !== 1'b1 && t < 4000);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        {num_errors, n_tests, npulse, nwrst, nadc} = '0;
        rst = 1'b1; hsel = 1'b1; haddr = '0; htrans = '0; hwrite = 1'b0;
        hsize = 3'b010; hwdata = '0; adc_enabled = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(A_CNT, 32'h0);
        rchk(A_PER, 32'hff);
        rchk(A_CTL, 32'h0);
        rchk(A_FLG, 32'h0);
        rchk(A_UCT, 32'h0);
        rchk(A_ENA, 32'h0);
        rchk(32'h100, 32'h0);
        rchk(A_PER | 32'h400, 32'h0); // out-of-range read refused
        rchk(A_PER + 32'h1, 32'h0); // misaligned read refused
        check(hresp, 1'b0);
        $display("test reset done");
        bus(1'b1, A_PER, 32'h5a);
        rchk(A_PER, 32'h5a);
        bus(1'b1, A_ENA, 32'h04);
        rchk(A_ENA, 32'h04);
        bus(1'b1, A_CLO, 32'ha5);
        bus(1'b1, A_CHI, 32'h3c);
        rchk(A_CLO, 32'ha5);
        rchk(A_CHI, 32'h3c);
        bus(1'b1, A_UCT, 32'h30);
        rchk(A_UCT, 32'h30);
        bus(1'b1, 32'h100, 32'h77);
        rchk(32'h100, 32'h0);
        bus(1'b1, A_ENA, 32'h00); // unit interrupt kept off through mode changes
        $display("test access done");
        bus(1'b1, A_PER, 32'h1f);
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b1, A_CTL, 32'h1c | c);
            wait_pulse();
            wait_pulse();
            check(t, 32 * (c == 0 ? 1 : (c == 1 ? 4 : 16)));
        end
        $display("test prescale done");
        for (int i = 0; i < 3; i++)
        begin
            n = (i == 2) ? 15 : i;
            bus(1'b1, A_CTL, (n << 3) | 32'h04);
            bus(1'b1, A_FLG, 32'h0);
            wait_flag();
            snap = npulse;
            bus(1'b1, A_FLG, 32'h0);
            wait_flag();
            check(npulse - snap, n + 1);
        end
        $display("test postscale done");
        bus(1'b1, A_CTL, 32'h00);
        bus(1'b0, A_CNT, 32'h0);
        snap = rd;
        repeat (100) @(posedge clk);
        rchk(A_CNT, snap);
        bus(1'b1, A_CNT, 32'h05);
        bus(1'b1, A_CTL, 32'h78);
        rchk(A_CNT, 32'h05);
        rchk(A_CTL, 32'h78);
        $display("test stop done");
        for (int s = 0; s < 4; s++)
            for (int m = 12; m < 16; m++)
            begin
                bus(1'b1, A_UCT, (s << 6) | m);
                settle();
                check(drive_out_oe, s == 0 ? 4'h1 : (s == 2 ? 4'h3 : 4'hf));
                check(drive_out_a, m[1]);
            end
        $display("test pwm done");
        bus(1'b1, A_UCT, 32'h0);
        settle();
        check(drive_out_a, 1'b0);
        bus(1'b1, A_CLO, 32'h34);
        bus(1'b1, A_CHI, 32'h12);
        for (int i = 0; i < 4; i++)
        begin
            n = (i == 0) ? 2 : (i == 1 ? 9 : (i == 2 ? 8 : 10));
            bus(1'b1, A_UCT, n);
            bus(1'b1, A_FLG, 32'h0);
            ptc_partner_inst.match(16'h1234);
            settle();
            check(unit_event_flag, 1'b1);
            if (i < 3)
                check(drive_out_a, i != 1);
        end
        for (int i = 0; i < 2; i++)
        begin
            adc_enabled <= (i == 0);
            snap = nadc;
            n = nwrst;
            bus(1'b1, A_UCT, 32'h0b);
            ptc_partner_inst.match(16'h1234);
            settle();
            check(nwrst - n, 1);
            check(nadc - snap, i == 0);
        end
        $display("test compare done");
        for (int m = 4; m < 8; m++)
        begin
            n = (m < 6) ? 1 : (m == 6 ? 4 : 16);
            bus(1'b1, A_UCT, 32'h0);
            bus(1'b1, A_UCT, m);
            bus(1'b1, A_FLG, 32'h0);
            ptc_partner_inst.pulses(n - 1, 16'h0100);
            settle();
            check(unit_event_flag, 1'b0);
            ptc_partner_inst.pulses(1, 16'h0a00 + m);
            settle();
            check(unit_event_flag, 1'b1);
            rchk(A_CLO, m == 4 ? m + 1 : m);
            rchk(A_CHI, 32'h0a);
        end
        bus(1'b1, A_UCT, 32'h05);
        ptc_partner_inst.pulses(1, 16'h1111);
        ptc_partner_inst.pulses(1, 16'h2222);
        rchk(A_CHI, 32'h22);
        bus(1'b1, A_UCT, 32'h06);
        ptc_partner_inst.pulses(2, 16'h0200);
        bus(1'b1, A_UCT, 32'h00);
        bus(1'b1, A_UCT, 32'h06);
        bus(1'b1, A_FLG, 32'h0);
        ptc_partner_inst.pulses(3, 16'h0300);
        settle();
        check(unit_event_flag, 1'b0);
        ptc_partner_inst.pulses(1, 16'h3333);
        settle();
        check(unit_event_flag, 1'b1);
        rchk(A_CLO, 32'h33);
        for (int i = 1; i < 4; i += 2)
        begin
            bus(1'b1, A_UCT, i);
            bus(1'b1, A_FLG, 32'h0);
            ptc_partner_inst.pulses(1, 16'h4444);
            ptc_partner_inst.match(16'h3333);
            settle();
            check(unit_event_flag, 1'b0);
        end
        $display("test capture done");
        stop_test();
    end
endmodule
